//--- bench/sdci_host.sv
`timescale 1ns/1ps
module sdci_host
    import sdci_pkg::*;
(
    input  wire logic            clk_sys_i, // system clock
    input  wire logic            sdo_i,     // readback bit
    input  wire logic            sdo_oe_i,  // readback enable
    output sdci_pkg::sdci_pins_t pins_o     // pins to the device
);
    sdci_pins_t p_q = '1; // idle: every pin high
    logic       line;
    // a released line shows the inverse, so a stale bit cannot pass
    assign line = sdo_oe_i ? sdo_i : ~sdo_i;
    assign pins_o = p_q;
    // one frame of n falling edges at 225 ns, msb first; readback sampled just before each fall
    task automatic frame(input logic [23:0] w, input int n, output logic [23:0] rd);
        rd = '0;
        @(posedge clk_sys_i) p_q.sync_n <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            p_q.serial_in_pin <= (i < 24) ? w[i] : 1'b0;
            repeat (4) @(posedge clk_sys_i);
            @(negedge clk_sys_i) rd = {rd[22:0], line};
            @(posedge clk_sys_i) p_q.sclk <= 1'b0;
            repeat (4) @(posedge clk_sys_i);
            p_q.sclk <= 1'b1;
        end
        repeat (4) @(posedge clk_sys_i);
        p_q.sync_n <= 1'b1;
        p_q.serial_in_pin <= ~p_q.serial_in_pin; // idle data differs from the last bit
        repeat (8) @(posedge clk_sys_i);
    endtask : frame
endmodule : sdci_host

//--- bench/sdci_top_properties.sv
`timescale 1ns/1ps
module sdci_top_properties
    import sdci_pkg::*;
(
    input wire logic                 clk_sys_i,          // system clock
    input wire logic                 nrst_i,             // reset, active low
    input wire sdci_pkg::sdci_pins_t pins_i,             // host pins
    input wire logic [19:0]          dac_code_o,         // output code
    input wire logic                 ground_clamp_o,     // clamp on
    input wire logic                 dac_tristate_o,     // tristated
    input wire logic                 amp_bypass_o,       // buffer bypass
    input wire logic                 serial_out_pin_o,   // readback bit
    input wire logic                 serial_out_pin_oe_o // readback enable
);
    // windows are long enough to cover the two-flop pin synchronisers
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    a_clamp_tri: assert property (ground_clamp_o |-> dac_tristate_o) else $error("clamp without tristate");
    a_oe_idle: assert property (pins_i.sync_n [*3] |-> !serial_out_pin_oe_o) else $error("sdo driven idle");
    a_oe_sync: assert property (serial_out_pin_oe_o |-> !$past(pins_i.sync_n, 2) || !$past(pins_i.sync_n, 3))
        else $error("sdo driven without select");
    a_pin_rst_code: assert property (!pins_i.reset_n [*4] |-> dac_code_o == CODE_RESET)
        else $error("code not held in reset");
    a_pin_rst_cfg: assert property (!pins_i.reset_n [*4] |-> ground_clamp_o && amp_bypass_o)
        else $error("config not held in reset");
    a_nrst_release: assert property ($rose(nrst_i) |-> dac_code_o == CODE_RESET && ground_clamp_o && amp_bypass_o)
        else $error("bad state after reset");
    a_clear_hold: assert property ((!pins_i.clear_n && pins_i.sync_n && pins_i.reset_n) [*8] |-> $stable(dac_code_o))
        else $error("code moved under clear");
    a_frame_hold: assert property ((!pins_i.sync_n && pins_i.load_update_n && pins_i.clear_n && pins_i.reset_n) [*6]
        |-> $stable(dac_code_o)) else $error("code moved mid frame");
    a_load_update_n_hold: assert property ((pins_i.load_update_n && pins_i.clear_n && pins_i.sync_n && pins_i.reset_n) [*8]
        |-> $stable(dac_code_o)) else $error("code moved without load");
    c_readback: cover property ($rose(serial_out_pin_oe_o));
    c_unclamp: cover property ($fell(ground_clamp_o));
    c_update: cover property ($changed(dac_code_o));
endmodule : sdci_top_properties
bind sdci_top sdci_top_properties u_sdci_top_properties (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .pins_i(pins_i),
    .dac_code_o(dac_code_o), .ground_clamp_o(ground_clamp_o), .dac_tristate_o(dac_tristate_o),
    .amp_bypass_o(amp_bypass_o), .serial_out_pin_o(serial_out_pin_o), .serial_out_pin_oe_o(serial_out_pin_oe_o));

//--- bench/sdci_top_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module sdci_top_tb;
    import sdci_pkg::*;
    logic        clk_sys_i = 1'b0;
    logic        nrst_i    = 1'b0;
    sdci_pins_t  pins;
    logic [19:0] code;
    logic        clamp, tris, bypass, serial_out_pin, sdo_oe;
    logic [23:0] rd;
    int          n_errors  = 0;
    int          checks    = 0;
    always #12.5 clk_sys_i = ~clk_sys_i;
    sdci_top u_sdci_top (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .pins_i(pins), .dac_code_o(code),
        .ground_clamp_o(clamp), .dac_tristate_o(tris), .amp_bypass_o(bypass), .serial_out_pin_o(serial_out_pin),
        .serial_out_pin_oe_o(sdo_oe));
    sdci_host u_sdci_host (.clk_sys_i(clk_sys_i), .sdo_i(serial_out_pin), .sdo_oe_i(sdo_oe), .pins_o(pins));
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic wr(input logic [2:0] a, input logic [19:0] d);
        u_sdci_host.frame({1'b0, a, d}, 24, rd);
    endtask : wr
    task automatic rq(input logic [2:0] a);
        u_sdci_host.frame({1'b1, a, 20'hF_FFFF}, 24, rd);
    endtask : rq
    // level pins, then time for the synchronisers and the update
    task automatic lvl(input logic l, input logic c, input logic r);
        @(posedge clk_sys_i);
        u_sdci_host.p_q.load_update_n <= l;
        u_sdci_host.p_q.clear_n <= c;
        u_sdci_host.p_q.reset_n <= r;
        repeat (6) @(posedge clk_sys_i);
    endtask : lvl
    task automatic report_and_stop;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    // watchdog well beyond the ~5400 cycles the sequence needs
    initial begin
        repeat (30000) @(posedge clk_sys_i);
        n_errors++;
        report_and_stop();
    end
    initial begin
        repeat (20) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        `CHK("rst", {CODE_RESET, 3'b111}, {code, clamp, tris, bypass})
        lvl(1'b0, 1'b1, 1'b1);
        wr(ADDR_OUT_CODE, 20'h1_2345);
        `CHK("sync upd", 20'h1_2345, code)
        wr(ADDR_MODE_CFG, 20'h0_0000);
        `CHK("cfg", 3'b000, {clamp, tris, bypass})
        wr(ADDR_MODE_CFG, 20'h0_0008);
        `CHK("tri only", 3'b010, {clamp, tris, bypass})
        wr(ADDR_MODE_CFG, 20'h0_0000);
        wr(ADDR_CLR_VALUE, 20'h0_ABCD);
        // chained reads: each frame returns the request before it
        rq(ADDR_OUT_CODE);
        rq(ADDR_MODE_CFG);
        `CHK("rd code", {1'b1, ADDR_OUT_CODE, 20'h1_2345}, rd)
        rq(ADDR_CLR_VALUE);
        `CHK("rd cfg", {1'b1, ADDR_MODE_CFG, 20'h0_0000}, rd)
        rq(ADDR_SOFT_CMD);
        `CHK("rd clrv", {1'b1, ADDR_CLR_VALUE, 20'h0_ABCD}, rd)
        rq(ADDR_NOP);
        `CHK("rd cmd", 24'h00_0000, rd)
        wr(ADDR_NOP, 20'hF_FFFF);
        `CHK("rd nop", {24'h00_0000, 20'h1_2345}, {rd, code})
        for (int n = 23; n <= 25; n += 2) begin
            u_sdci_host.frame({1'b0, ADDR_OUT_CODE, 20'hF_FFFF}, n, rd);
            `CHK("bad len", 20'h1_2345, code)
        end
        lvl(1'b1, 1'b1, 1'b1);
        wr(ADDR_OUT_CODE, 20'h5_4321);
        `CHK("deferred", 20'h1_2345, code)
        lvl(1'b0, 1'b1, 1'b1);
        `CHK("load_update_n fall", 20'h5_4321, code)
        lvl(1'b1, 1'b1, 1'b1);
        wr(ADDR_OUT_CODE, 20'h0_7777);
        wr(ADDR_SOFT_CMD, 20'h0_0001);
        `CHK("soft load", 20'h0_7777, code)
        lvl(1'b0, 1'b0, 1'b1);
        `CHK("clear", 20'h0_ABCD, code)
        lvl(1'b0, 1'b1, 1'b1);
        `CHK("clear end", 20'h0_ABCD, code)
        wr(ADDR_OUT_CODE, 20'h2_2222);
        wr(ADDR_SOFT_CMD, 20'h0_0002);
        `CHK("soft clear", 20'h0_ABCD, code)
        lvl(1'b0, 1'b0, 1'b1);
        wr(ADDR_OUT_CODE, 20'h1_1111);
        `CHK("clear blk", 20'h0_ABCD, code)
        wr(ADDR_SOFT_CMD, 20'h0_0004);
        `CHK("soft rst", {20'h0_0000, 3'b111}, {code, clamp, tris, bypass})
        lvl(1'b0, 1'b1, 1'b1);
        wr(ADDR_MODE_CFG, 20'h0_0000);
        wr(ADDR_OUT_CODE, 20'h3_3333);
        lvl(1'b0, 1'b1, 1'b0);
        wr(ADDR_OUT_CODE, 20'h4_4444);
        `CHK("pin rst", {20'h0_0000, 3'b111}, {code, clamp, tris, bypass})
        lvl(1'b0, 1'b1, 1'b1);
        `CHK("rst end", 20'h0_0000, code)
        report_and_stop();
    end
endmodule : sdci_top_tb

//--- src/sdci_pkg.sv
package sdci_pkg;

    // ------------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------------
    localparam int unsigned FRAME_BITS = 24;
    localparam int unsigned DATA_BITS  = 20;
    localparam int unsigned RW_BIT     = 23;
    localparam int unsigned ADDR_MSB   = 22;
    localparam int unsigned ADDR_LSB   = 20;
    localparam int unsigned DATA_MSB   = 19;

    localparam logic [4:0] FRAME_LEN  = 5'd24;  // exact count of falling shift clock edges
    localparam logic [4:0] FRAME_OVER = 5'd25;  // saturating count marking an over-long frame

    // ------------------------------------------------------------------
    // register addresses (frame address field)
    // ------------------------------------------------------------------
    localparam logic [2:0] ADDR_NOP       = 3'h0;
    localparam logic [2:0] ADDR_OUT_CODE  = 3'h1;
    localparam logic [2:0] ADDR_MODE_CFG  = 3'h2;
    localparam logic [2:0] ADDR_CLR_VALUE = 3'h3;
    localparam logic [2:0] ADDR_SOFT_CMD  = 3'h4;

    // ------------------------------------------------------------------
    // mode_config_reg fields and reset values
    // ------------------------------------------------------------------
    localparam int unsigned CFG_RBUF_BIT    = 1;
    localparam int unsigned CFG_CLAMP_BIT   = 2;  // output_ground_clamp
    localparam int unsigned CFG_TRI_BIT     = 3;
    localparam int unsigned CFG_SDO_DIS_BIT = 5;

    localparam logic [19:0] CFG_RESET   = 20'h0_0006;  // buffer bypass and ground clamp on
    localparam logic [19:0] CODE_RESET  = 20'h0_0000;
    localparam logic [19:0] CLRV_RESET  = 20'h0_0000;
    localparam logic [23:0] SHIFT_RESET = 24'h00_0000;

    // ------------------------------------------------------------------
    // soft_command_reg fields
    // ------------------------------------------------------------------
    localparam int unsigned CMD_LOAD_BIT  = 0;
    localparam int unsigned CMD_CLEAR_BIT = 1;
    localparam int unsigned CMD_RESET_BIT = 2;

    // ------------------------------------------------------------------
    // pin group and state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic sclk;            // serial shift clock
        logic sync_n;          // frame select, active low
        logic serial_in_pin;   // serial data in
        logic load_update_n;   // load-update, active low
        logic clear_n;         // clear, active low
        logic reset_n;         // reset pin, active low
    } sdci_pins_t;

    typedef struct packed {
        logic [2:0]  sclk_sy;   // [0] first stage, [1] second, [2] edge history
        logic [2:0]  sync_sy;
        logic [1:0]  serial_in_pin_sy;
        logic [2:0]  load_update_n_sy;
        logic [1:0]  clr_sy;
        logic [1:0]  rst_sy;
        logic [23:0] shift;     // input shift register
        logic [4:0]  cnt;       // falling edges seen this frame
        logic [23:0] rd_shift;  // readback shifter, msb on the pin
        logic [19:0] code_pend; // written code awaiting an update
        logic        pend;
        logic [19:0] code;      // output_code_reg
        logic [19:0] cfg;       // mode_config_reg
        logic [19:0] clrv;      // clear_value_reg
    } sdci_state_t;

endpackage : sdci_pkg

//--- src/sdci_top.sv
// Contract
// - 24-bit frames, msb first, on shift clock
// - bit 23 read/write, 22:20 address, data below
// - write frames load the addressed register
// - read frames select code, config, clear readback
// - address zero does nothing at all
// - frames short of 24 edges are dropped
// - frames over 24 edges are dropped
// - select rise latches and applies the frame
// - shift clock rates up to stated limit
// - next frame shifts read data out
// - serial out released while select high
// - serial out enabled after reset
// - load-update low: update at select rise
// - load-update high: update at its falling edge
// - reset pin low holds all in reset
// - software reset equals reset pin
// - clear low loads clear value into code
// - clear blocks updates; clear value persists after
// - software clear equals clear pin
// - otherwise output follows output code register
// - any reset selects ground clamp mode
`timescale 1ns/1ps
module sdci_top
    import sdci_pkg::*;
(
    input  wire logic              clk_sys_i,            // system clock, 40 MHz
    input  wire logic              nrst_i,               // asynchronous reset, active low
    input  wire sdci_pkg::sdci_pins_t pins_i,            // asynchronous pins from the host
    output logic [19:0]            dac_code_o,           // code presented to the converter
    output logic                   ground_clamp_o,       // output clamped to ground
    output logic                   dac_tristate_o,       // converter output tristated
    output logic                   amp_bypass_o,         // buffer configuration bit
    output logic                   serial_out_pin_o,     // readback data
    output logic                   serial_out_pin_oe_o   // readback drive enable
);
    import sdci_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    sdci_state_t s_q;
    sdci_state_t s_d;

    // field extraction used by decode and readback
    function automatic logic [2:0] frame_addr(input logic [23:0] f);
        frame_addr = f[ADDR_MSB:ADDR_LSB];
    endfunction : frame_addr

    function automatic logic [19:0] frame_data(input logic [23:0] f);
        frame_data = f[DATA_MSB:0];
    endfunction : frame_data

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    // all pins pass two flops first; edges are found one stage later so
    // the first stage only ever feeds the second
    always_comb begin
        logic sclk_fall;
        logic sync_fall;
        logic sync_rise;
        logic load_update_n_fall;
        logic clear_act;
        logic soft_rst;
        logic soft_clr;
        logic soft_load;
        logic valid;
        logic [2:0] addr;
        logic [19:0] data;
        sclk_fall = 1'b0;
        sync_fall = 1'b0;
        sync_rise = 1'b0;
        load_update_n_fall = 1'b0;
        clear_act = 1'b0;
        soft_rst  = 1'b0;
        soft_clr  = 1'b0;
        soft_load = 1'b0;
        valid     = 1'b0;
        addr      = frame_addr(s_q.shift);
        data      = frame_data(s_q.shift);
        s_d       = s_q;

        // oversampling caps the shift clock near an eighth of the system clock
        s_d.sclk_sy = {s_q.sclk_sy[1:0], pins_i.sclk};
        s_d.sync_sy = {s_q.sync_sy[1:0], pins_i.sync_n};
        s_d.serial_in_pin_sy = {s_q.serial_in_pin_sy[0], pins_i.serial_in_pin};
        s_d.load_update_n_sy = {s_q.load_update_n_sy[1:0], pins_i.load_update_n};
        s_d.clr_sy  = {s_q.clr_sy[0], pins_i.clear_n};
        s_d.rst_sy  = {s_q.rst_sy[0], pins_i.reset_n};

        sclk_fall = s_q.sclk_sy[2] & ~s_q.sclk_sy[1];
        sync_fall = s_q.sync_sy[2] & ~s_q.sync_sy[1];
        sync_rise = ~s_q.sync_sy[2] & s_q.sync_sy[1];
        load_update_n_fall = s_q.load_update_n_sy[2] & ~s_q.load_update_n_sy[1];

        // frame start clears the count
        if (sync_fall) begin
            s_d.cnt = 5'd0;
        end

        // shift on each falling edge while selected; count saturates past 24
        if (sclk_fall && !s_q.sync_sy[1]) begin
            s_d.shift = {s_q.shift[FRAME_BITS-2:0], s_q.serial_in_pin_sy[1]};
            s_d.rd_shift = {s_q.rd_shift[FRAME_BITS-2:0], 1'b0};
            if (s_q.cnt != FRAME_OVER) begin
                s_d.cnt = s_q.cnt + 5'd1;
            end
        end

        // readback data is dropped once the frame that carries it ends
        if (sync_rise) begin
            s_d.rd_shift = SHIFT_RESET;
            valid = (s_q.cnt == FRAME_LEN);
        end

        // apply a complete frame at select rise
        if (valid && addr != ADDR_NOP) begin
            if (!s_q.shift[RW_BIT]) begin
                case (addr)
                    ADDR_OUT_CODE: begin
                        s_d.code_pend = data;
                        if (!s_q.load_update_n_sy[1]) begin
                            s_d.code = data;
                            s_d.pend = 1'b0;
                        end else begin
                            s_d.pend = 1'b1;
                        end
                    end
                    ADDR_MODE_CFG:  s_d.cfg  = data;
                    ADDR_CLR_VALUE: s_d.clrv = data;
                    ADDR_SOFT_CMD: begin
                        soft_load = data[CMD_LOAD_BIT];
                        soft_clr  = data[CMD_CLEAR_BIT];
                        soft_rst  = data[CMD_RESET_BIT];
                    end
                    default: ;
                endcase
            end else begin
                case (addr)
                    ADDR_OUT_CODE:  s_d.rd_shift = {1'b1, addr, s_q.code};
                    ADDR_MODE_CFG:  s_d.rd_shift = {1'b1, addr, s_q.cfg};
                    ADDR_CLR_VALUE: s_d.rd_shift = {1'b1, addr, s_q.clrv};
                    default: ;  // command register is write only
                endcase
            end
        end

        // deferred update on load-update fall or software load
        if ((load_update_n_fall || soft_load) && s_q.pend) begin
            s_d.code = s_q.code_pend;
            s_d.pend = 1'b0;
        end

        // clear wins over any update in the same cycle and cancels pending
        clear_act = ~s_q.clr_sy[1] | soft_clr;
        if (clear_act) begin
            s_d.code = s_d.clrv;
            s_d.pend = 1'b0;
        end

        // pin reset holds everything; software reset takes the same defaults
        if (!s_q.rst_sy[1] || soft_rst) begin
            s_d.shift     = SHIFT_RESET;
            s_d.cnt       = FRAME_OVER;  // a frame in flight is void
            s_d.rd_shift  = SHIFT_RESET;
            s_d.code_pend = CODE_RESET;
            s_d.pend      = 1'b0;
            s_d.code      = CODE_RESET;
            s_d.cfg       = CFG_RESET;
            s_d.clrv      = CLRV_RESET;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // idle pin levels are taken as reset values to avoid false edges
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q.sclk_sy   <= 3'h7;
            s_q.sync_sy   <= 3'h7;
            s_q.serial_in_pin_sy   <= 2'h0;
            s_q.load_update_n_sy   <= 3'h7;
            s_q.clr_sy    <= 2'h3;
            s_q.rst_sy    <= 2'h3;
            s_q.shift     <= SHIFT_RESET;
            s_q.cnt       <= FRAME_OVER;
            s_q.rd_shift  <= SHIFT_RESET;
            s_q.code_pend <= CODE_RESET;
            s_q.pend      <= 1'b0;
            s_q.code      <= CODE_RESET;
            s_q.cfg       <= CFG_RESET;
            s_q.clrv      <= CLRV_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // clamp overrides the tristate bit, so both raise the tristate output
    assign dac_code_o          = s_q.code;
    assign ground_clamp_o      = s_q.cfg[CFG_CLAMP_BIT];
    assign dac_tristate_o      = s_q.cfg[CFG_CLAMP_BIT] | s_q.cfg[CFG_TRI_BIT];
    assign amp_bypass_o        = s_q.cfg[CFG_RBUF_BIT];
    assign serial_out_pin_o    = s_q.rd_shift[FRAME_BITS-1];
    assign serial_out_pin_oe_o = ~s_q.sync_sy[1] & ~s_q.cfg[CFG_SDO_DIS_BIT];

endmodule : sdci_top
